// *** rdac_ctrl.sv ***
// Module: top of the reference converter control with Avalon-MM slave
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module rdac_ctrl
    import rdac_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pads seen by the digital input path
    input wire logic pad_one_in,
    input wire logic pad_two_in,
    // Analog ladder controls
    output logic converter_on,
    output logic [4:0] level_code,
    output logic [1:0] high_end_source_field,
    output logic low_end_source_bit,
    output logic [1:0] level_pin_drive_enables,
    // Pin one overrides and read value
    output logic level_pin_one_out_buf_off,
    output logic level_pin_one_in_det_off,
    output logic level_pin_one_pullup_off,
    output logic level_pin_one_cur_drive_off,
    output logic level_pin_one_read,
    // Pin two overrides and read value
    output logic level_pin_two_out_buf_off,
    output logic level_pin_two_in_det_off,
    output logic level_pin_two_pullup_off,
    output logic level_pin_two_cur_drive_off,
    output logic level_pin_two_read
);
    typedef struct packed {
        rdac_bus_st_t bus_st;
        logic wreq;
        logic [31:0] rdata;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] ovr_buf;
        logic [1:0] ovr_det;
        logic [1:0] ovr_pu;
        logic [1:0] ovr_cd;
        logic [1:0] rd_val;
        logic [4:0] ladder_code;
        logic [1:0] hi_src;
        logic lo_src;
        logic conv_on;
        logic [1:0] pin_en;
    } rdac_state_t;

    rdac_state_t s_q;
    rdac_state_t s_d;
    logic [7:0] wr_byte;
    logic [7:0] status;

    rdac_pin_if p1();
    rdac_pin_if p2();

    // Pad overrides follow the stored enable bits
    assign p1.ref_out_sel = s_q.ctrl0[RDAC_BIT_PIN_ONE];
    assign p2.ref_out_sel = s_q.ctrl0[RDAC_BIT_PIN_TWO];
    assign p1.pad_in = s_q.sync2[0];
    assign p2.pad_in = s_q.sync2[1];

    rdac_pin_override u_pin_one (
        .pin(p1)
    );
    rdac_pin_override u_pin_two (
        .pin(p2)
    );

    // Byte lane 0 carries the 8-bit register
    assign wr_byte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    // Live view of what the ladder currently sees
    assign status = {s_q.conv_on, 2'h0, s_q.ladder_code};

    // Next-state logic: bus slave, register file and output staging
    always_comb begin
        s_d = s_q;
        s_d.sync1 = {pad_two_in, pad_one_in};
        s_d.sync2 = s_q.sync1;
        unique case (s_q.bus_st)
            RDAC_BUS_IDLE: begin
                // One wait cycle, then accept; keeps readdata registered
                if (avs_read || avs_write) begin
                    s_d.bus_st = RDAC_BUS_ACK;
                    s_d.wreq = 1'b0;
                    s_d.rdata = RDAC_UNMAPPED_DATA;
                    if (avs_read) begin
                        unique case (avs_address)
                            RDAC_ADDR_ENABLE_SOURCE:
                                s_d.rdata = {24'h0, s_q.ctrl0};
                            RDAC_ADDR_LEVEL_SELECT:
                                s_d.rdata = {24'h0, s_q.ctrl1};
                            RDAC_ADDR_STATUS:
                                s_d.rdata = {24'h0, status};
                            default: s_d.rdata = RDAC_UNMAPPED_DATA;
                        endcase
                    end
                    if (avs_write && avs_byteenable[0]) begin
                        // Masks keep unimplemented bits at zero
                        if (avs_address == RDAC_ADDR_ENABLE_SOURCE) begin
                            s_d.ctrl0 = wr_byte & RDAC_MASK_ENABLE_SOURCE;
                        end
                        if (avs_address == RDAC_ADDR_LEVEL_SELECT) begin
                            s_d.ctrl1 = wr_byte & RDAC_MASK_LEVEL_SELECT;
                        end
                    end
                end
            end
            RDAC_BUS_ACK: begin
                s_d.bus_st = RDAC_BUS_IDLE;
                s_d.wreq = 1'b1;
            end
        endcase
        // Analog controls staged from stored registers, one edge after write
        s_d.conv_on = s_q.ctrl0[RDAC_BIT_CONVERTER_ON];
        s_d.ladder_code = s_q.ctrl1[4:0];
        s_d.pin_en = {s_q.ctrl0[RDAC_BIT_PIN_TWO],
                      s_q.ctrl0[RDAC_BIT_PIN_ONE]};
        // Reserved code passed as written; software must avoid it
        s_d.hi_src = s_q.ctrl0[RDAC_HI_SRC_MSB:RDAC_HI_SRC_LSB];
        s_d.lo_src = s_q.ctrl0[RDAC_BIT_LOW_SRC];
        s_d.ovr_buf = {p2.out_buf_off, p1.out_buf_off};
        s_d.ovr_det = {p2.in_det_off, p1.in_det_off};
        s_d.ovr_pu = {p2.pullup_off, p1.pullup_off};
        s_d.ovr_cd = {p2.cur_drive_off, p1.cur_drive_off};
        s_d.rd_val = {p2.read_value, p1.read_value};
    end

    // No sleep input: clock keeps running, so state survives a wake
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.bus_st <= RDAC_BUS_IDLE;
            s_q.wreq <= 1'b1;
            s_q.ctrl0 <= RDAC_RST_ENABLE_SOURCE;
            s_q.ctrl1 <= RDAC_RST_LEVEL_SELECT;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.wreq; // High when idle, low in answer cycle
    assign converter_on = s_q.conv_on;
    assign level_code = s_q.ladder_code;
    assign high_end_source_field = s_q.hi_src;
    assign low_end_source_bit = s_q.lo_src;
    assign level_pin_drive_enables = s_q.pin_en;
    assign level_pin_one_out_buf_off = s_q.ovr_buf[0];
    assign level_pin_one_in_det_off = s_q.ovr_det[0];
    assign level_pin_one_pullup_off = s_q.ovr_pu[0];
    assign level_pin_one_cur_drive_off = s_q.ovr_cd[0];
    assign level_pin_one_read = s_q.rd_val[0];
    assign level_pin_two_out_buf_off = s_q.ovr_buf[1];
    assign level_pin_two_in_det_off = s_q.ovr_det[1];
    assign level_pin_two_pullup_off = s_q.ovr_pu[1];
    assign level_pin_two_cur_drive_off = s_q.ovr_cd[1];
    assign level_pin_two_read = s_q.rd_val[1];
endmodule : rdac_ctrl
`default_nettype wire

// *** rdac_pad_model.sv ***
// Partner: pad pins seen by the digital input path
`timescale 1ns/10ps
`default_nettype none
module rdac_pad_model (
    // Bench levels and converter pin enables
    input wire logic [1:0] ext_level,
    input wire logic [1:0] level_on_pin,
    // Pad levels toward the synchronisers
    output logic pad_one_in,
    output logic pad_two_in
);
    // A pin carrying the level looks high, the worst case for a read
    assign pad_one_in = ext_level[0] | level_on_pin[0];
    assign pad_two_in = ext_level[1] | level_on_pin[1];
endmodule : rdac_pad_model
`default_nettype wire

// *** rdac_pin_if.sv ***
// Interface: per-pin override bundle between top and pin override module
`timescale 1ns/10ps
`default_nettype none
interface rdac_pin_if;
    logic ref_out_sel;
    logic pad_in;
    logic out_buf_off;
    logic in_det_off;
    logic pullup_off;
    logic cur_drive_off;
    logic read_value;
    modport ovr (
        input ref_out_sel,
        input pad_in,
        output out_buf_off,
        output in_det_off,
        output pullup_off,
        output cur_drive_off,
        output read_value
    );
    modport top (
        output ref_out_sel,
        output pad_in,
        input out_buf_off,
        input in_det_off,
        input pullup_off,
        input cur_drive_off,
        input read_value
    );
endinterface : rdac_pin_if
`default_nettype wire

// *** rdac_pin_override.sv ***
// Module: combinational pad override for one reference output pin
`timescale 1ns/10ps
`default_nettype none
module rdac_pin_override
    import rdac_pkg::*;
(
    // Pin bundle
    rdac_pin_if.ovr pin
);
    // Reference output forces all digital pad functions off
    always_comb begin
        pin.out_buf_off = pin.ref_out_sel;
        pin.in_det_off = pin.ref_out_sel;
        pin.pullup_off = pin.ref_out_sel;
        pin.cur_drive_off = pin.ref_out_sel;
        // Detector off, so the digital read is forced low
        pin.read_value = pin.ref_out_sel ? 1'b0 : pin.pad_in;
    end
endmodule : rdac_pin_override
`default_nettype wire

// *** rdac_pkg.sv ***
// Package: register map, field positions and reset values of the reference converter control
package rdac_pkg;
    // Register byte addresses on the Avalon word bus
    localparam logic [3:0] RDAC_ADDR_ENABLE_SOURCE = 4'h0;
    localparam logic [3:0] RDAC_ADDR_LEVEL_SELECT = 4'h4;
    localparam logic [3:0] RDAC_ADDR_STATUS = 4'h8;
    // Field positions in ref_enable_source_ctrl
    localparam int RDAC_BIT_CONVERTER_ON = 7;
    localparam int RDAC_BIT_PIN_ONE = 5;
    localparam int RDAC_BIT_PIN_TWO = 4;
    localparam int RDAC_HI_SRC_MSB = 3;
    localparam int RDAC_HI_SRC_LSB = 2;
    localparam int RDAC_BIT_LOW_SRC = 0;
    // Writable bit masks; unimplemented bits read zero
    localparam logic [7:0] RDAC_MASK_ENABLE_SOURCE = 8'hbd;
    localparam logic [7:0] RDAC_MASK_LEVEL_SELECT = 8'h1f;
    // Reset values
    localparam logic [7:0] RDAC_RST_ENABLE_SOURCE = 8'h00;
    localparam logic [7:0] RDAC_RST_LEVEL_SELECT = 8'h00;
    // Answer to an unmapped read
    localparam logic [31:0] RDAC_UNMAPPED_DATA = 32'h0000_0000;
    // Positive ladder end source codes
    typedef enum logic [1:0] {
        RDAC_HI_SUPPLY = 2'h0,
        RDAC_HI_EXT_PIN = 2'h1,
        RDAC_HI_FIXED_REF = 2'h2,
        RDAC_HI_RESERVED = 2'h3
    } rdac_hi_src_t;
    // Bus answer handshake states
    typedef enum logic [0:0] {
        RDAC_BUS_IDLE,
        RDAC_BUS_ACK
    } rdac_bus_st_t;
endpackage : rdac_pkg

// *** rdac_props.sv ***
// Checker: port properties of the converter control
`timescale 1ns/10ps
`default_nettype none
module rdac_ctrl_props
    import rdac_pkg::*;
(
    // Watched ports
    input wire logic ref_clk, rst_n, clk_en, avs_read, avs_write,
    input wire logic [3:0] avs_address, avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest, converter_on, low_end_source_bit,
    input wire logic [4:0] level_code,
    input wire logic [1:0] high_end_source_field, level_pin_drive_enables,
    input wire logic level_pin_one_out_buf_off, level_pin_one_in_det_off,
    input wire logic level_pin_one_pullup_off, level_pin_one_read,
    input wire logic level_pin_one_cur_drive_off, level_pin_two_read,
    input wire logic level_pin_two_out_buf_off, level_pin_two_in_det_off,
    input wire logic level_pin_two_pullup_off, level_pin_two_cur_drive_off
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Completed writes; the outputs move on the edge that completes them
    wire logic wr = avs_write && !avs_waitrequest && clk_en
        && avs_byteenable[0];
    wire logic wr0 = wr && avs_address == RDAC_ADDR_ENABLE_SOURCE;
    wire logic wr1 = wr && avs_address == RDAC_ADDR_LEVEL_SELECT;
    wire logic [7:0] wd = avs_writedata[7:0];
    a_enable_write: assert property (
        wr0 |=> converter_on == $past(wd[7])) else $error("bad enable");
    a_level_write: assert property (
        wr1 |=> level_code == $past(wd[4:0])) else $error("bad level");
    a_pin_enables: assert property (
        wr0 |=> level_pin_drive_enables == $past({wd[4], wd[5]}))
        else $error("bad pin enables");
    a_source_write: assert property (
        wr0 |=> {high_end_source_field, low_end_source_bit}
        == $past({wd[3:2], wd[0]})) else $error("bad sources");
    a_pad_override: assert property (
        {level_pin_one_out_buf_off, level_pin_one_in_det_off,
        level_pin_one_pullup_off, level_pin_one_cur_drive_off}
        == {4{level_pin_drive_enables[0]}}) else $error("bad override");
    a_pad_two_override: assert property (
        {level_pin_two_out_buf_off, level_pin_two_in_det_off,
        level_pin_two_pullup_off, level_pin_two_cur_drive_off}
        == {4{level_pin_drive_enables[1]}}) else $error("bad override two");
    a_read_zero: assert property (
        (level_pin_drive_enables & {level_pin_two_read, level_pin_one_read})
        == 2'h0) else $error("pin read not zero");
    a_hold_still: assert property (
        !wr0 |=> $stable({converter_on, level_pin_drive_enables}))
        else $error("state moved");
    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest && clk_en
        |=> !avs_waitrequest) else $error("late answer");
    a_reset_clear: assert property (disable iff (1'b0)
        !rst_n |=> !converter_on && level_code == 5'h0
        && level_pin_drive_enables == 2'h0) else $error("reset missed");
endmodule : rdac_ctrl_props
bind rdac_ctrl rdac_ctrl_props u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_address(avs_address), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .converter_on(converter_on), .low_end_source_bit(low_end_source_bit),
    .level_code(level_code),
    .high_end_source_field(high_end_source_field),
    .level_pin_drive_enables(level_pin_drive_enables),
    .level_pin_one_out_buf_off(level_pin_one_out_buf_off),
    .level_pin_one_in_det_off(level_pin_one_in_det_off),
    .level_pin_one_pullup_off(level_pin_one_pullup_off),
    .level_pin_one_cur_drive_off(level_pin_one_cur_drive_off),
    .level_pin_one_read(level_pin_one_read),
    .level_pin_two_read(level_pin_two_read),
    .level_pin_two_out_buf_off(level_pin_two_out_buf_off),
    .level_pin_two_in_det_off(level_pin_two_in_det_off),
    .level_pin_two_pullup_off(level_pin_two_pullup_off),
    .level_pin_two_cur_drive_off(level_pin_two_cur_drive_off));
`default_nettype wire

// *** testbench.sv ***
// Testbench: register table, pad override and reset checks
`timescale 1ns/10ps
`default_nettype none
module testbench
    import rdac_pkg::*;
;
    typedef struct {logic [3:0] a; logic [7:0] d, e;} rdac_row_t;
    // Bus, pad and ladder signals
    logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic pad_one_in, pad_two_in, converter_on, low_end_source_bit;
    logic level_pin_one_read, level_pin_two_read;
    logic [4:0] level_code;
    logic [1:0] high_end_source_field, level_pin_drive_enables;
    logic [1:0] ext_level = 2'h0;
    logic [7:0] rd;
    int num_errors = 0, cmp_count = 0;
    // Address, write data, readback; code 11 is never written
    rdac_row_t rows [8] = '{
        '{4'h0, 8'hf3, 8'hb1}, '{4'h4, 8'hff, 8'h1f},
        '{4'h0, 8'h08, 8'h08}, '{4'h0, 8'h04, 8'h04},
        '{4'h0, 8'h01, 8'h01}, '{4'h4, 8'h15, 8'h15},
        '{4'h8, 8'hff, 8'h15}, '{4'hc, 8'hff, 8'h00}};
    rdac_ctrl dut (.*,
        .level_pin_one_out_buf_off(), .level_pin_one_in_det_off(),
        .level_pin_one_pullup_off(), .level_pin_one_cur_drive_off(),
        .level_pin_two_out_buf_off(), .level_pin_two_in_det_off(),
        .level_pin_two_pullup_off(), .level_pin_two_cur_drive_off());
    rdac_pad_model pads (.ext_level(ext_level), .pad_one_in(pad_one_in),
        .level_on_pin(level_pin_drive_enables), .pad_two_in(pad_two_in));
    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // One transfer, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [7:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        // No wait count assumed; only the watchdog ends a hang
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // Some 23 transfers of 3 cycles; far beyond that is a hang
    initial begin
        repeat (4000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end
    // Reset, table rows, then the awkward cases
    initial begin
        repeat (20) @(posedge ref_clk);
        chk({converter_on, level_pin_drive_enables, level_code}, 8'h00);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, 4'h1);
            bus(1'b0, rows[i].a, 8'h00, 4'hf);
            chk(rd, rows[i].e);
        end
        // Lane 0 off drops the write
        bus(1'b1, 4'h0, 8'hf3, 4'he);
        bus(1'b0, 4'h0, 8'h00, 4'hf);
        chk(rd, 8'h01);
        // Pins carrying the level read zero, freed pins follow the pad
        ext_level <= 2'h3;
        bus(1'b1, 4'h0, 8'hb0, 4'h1);
        repeat (4) @(posedge ref_clk);
        chk({6'h0, level_pin_two_read, level_pin_one_read}, 8'h00);
        bus(1'b1, 4'h0, 8'h80, 4'h1);
        repeat (4) @(posedge ref_clk);
        chk({6'h0, level_pin_two_read, level_pin_one_read}, 8'h03);
        // Frozen clock stands for sleep; state must persist
        clk_en <= 1'b0;
        repeat (8) @(posedge ref_clk);
        clk_en <= 1'b1;
        chk({7'h0, converter_on}, 8'h01);
        // Mid-run reset clears outputs and registers
        bus(1'b1, 4'h4, 8'h1f, 4'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk({converter_on, level_pin_drive_enables, level_code}, 8'h00);
        bus(1'b0, 4'h4, 8'h00, 4'hf);
        chk(rd, 8'h00);
        bus(1'b0, 4'h0, 8'h00, 4'hf);
        chk(rd, 8'h00);
        summarize();
    end
endmodule : testbench
`default_nettype wire
